// [hdl/pam_defs.vh]
// register map, field positions and reset values of the port a pin mux
`ifndef PAM_DEFS_VH
`define PAM_DEFS_VH

`define PAM_ADDR_W          4
`define PAM_OFF_PINS        4'h0
`define PAM_OFF_LATCH       4'h1
`define PAM_OFF_DIR         4'h2
`define PAM_OFF_ANSEL       4'h3
`define PAM_OFF_SLEW        4'h4
`define PAM_OFF_OSC         4'h5
`define PAM_OFF_PERIPH      4'h6

`define PAM_ANSEL_MASK      8'h2F
`define PAM_SLEW_MASK       8'h1F
`define PAM_DIR_RST         8'hFF
`define PAM_ANSEL_RST       8'h2F
`define PAM_LATCH_RST       8'h00
`define PAM_SLEW_RST        8'h1F
`define PAM_OSC_RST         4'h8
`define PAM_PERIPH_RST      8'h00

// oscillator select codes
`define PAM_OSC_LP          4'h0
`define PAM_OSC_XT          4'h1
`define PAM_OSC_HS          4'h2
`define PAM_OSC_RC_INSTRUCTION_CLOCK_OUTPUT     4'h3
`define PAM_OSC_EC          4'h4
`define PAM_OSC_RC_IO       4'h7
`define PAM_OSC_INT_IO      4'h8
`define PAM_OSC_INT_INSTRUCTION_CLOCK_OUTPUT    4'h9

// peripheral enable register bit positions
`define PAM_PE_SRQ          0
`define PAM_PE_C1           1
`define PAM_PE_COMPARE_PWM_CHANNEL_FIVE         2
`define PAM_PE_LATCH_INVERTED_OUTPUT         3
`define PAM_PE_C2           4

`endif

// [hdl/pam_port_a_mux.v]
// port a pin function selection, priority mux and register file
`timescale 1ns/1ps
`include "pam_defs.vh"

// Functional notes
// - pin 6 latch output only in internal osc modes with clock out off
// - pin 6 digital input only in internal osc modes with clock out off
// - rc mode with clock out drives pin 6 at quarter oscillator rate
// - crystal mode gives pin 6 to oscillator output, ignoring dir/analog
// - external oscillator modes disable pin 7 latch output
// - external oscillator modes disable pin 7 digital input
// - pin 7 clock input belongs to oscillator input, never separate
// - enabled output functions sharing a pin: highest priority wins
// - analog inputs connect only while the pin is in analog mode
// - enabled digital outputs still drive pins in analog mode
// - analog select implements bits 0,1,2,3,5; bits 7,6,4 read zero
// - analog select disables that pin's digital input
// - after reset pin 4 is a digital input
module pam_port_a_mux (
   input  wire                   core_clk,
   input  wire                   resetn,
   input  wire [`PAM_ADDR_W-1:0] addr,
   input  wire [7:0]             wdata,
   input  wire                   wr,
   input  wire                   rd,
   output reg  [7:0]             rdata,
   input  wire [7:0]             pin_in,
   output reg  [7:0]             pin_out,
   output reg  [7:0]             pin_oe_n,
   output reg  [7:0]             pin_slew_limit,
   output reg  [7:0]             analog_connect,
   output reg                    osc_out_enable,
   output reg                    osc_in_enable,
   input  wire                   latch_q_output,
   input  wire                   latch_inverted_output,
   input  wire                   comparator_one_output,
   input  wire                   comparator_two_output,
   input  wire                   compare_pwm_channel_five
);

   reg  [7:0] first_port_output_latch;
   reg  [7:0] first_port_direction;
   reg  [7:0] first_port_analog_select;
   reg  [7:0] slew_rate_control;
   reg  [3:0] oscillator_select_field;
   reg  [7:0] periph_en;
   reg  [7:0] pin_meta;
   reg  [7:0] pin_sync;
   reg  [1:0] quarter_div;
   reg        quarter_rate_clock;

   // mode decode used by pin 6 and pin 7 logic
   function is_internal;
      input [3:0] m;
      begin
         is_internal = (m == `PAM_OSC_INT_IO) || (m == `PAM_OSC_INT_INSTRUCTION_CLOCK_OUTPUT);
      end
   endfunction

   function is_crystal;
      input [3:0] m;
      begin
         is_crystal = (m == `PAM_OSC_LP) || (m == `PAM_OSC_XT) ||
                      (m == `PAM_OSC_HS);
      end
   endfunction

   wire int_mode  = is_internal(oscillator_select_field);
   wire xtal_mode = is_crystal(oscillator_select_field);
   wire rc_instruction_clock_output   = (oscillator_select_field == `PAM_OSC_RC_INSTRUCTION_CLOCK_OUTPUT);
   wire int_instruction_clock_output  = (oscillator_select_field == `PAM_OSC_INT_INSTRUCTION_CLOCK_OUTPUT);
   wire instruction_clock_output = rc_instruction_clock_output || int_instruction_clock_output;
   // every non-internal mode uses pin 7 as oscillator input
   wire ext_mode  = !int_mode;

   wire pin6_gpio = int_mode && !instruction_clock_output;

   // digital input enables; analog pins read zero
   reg [7:0] in_en;
   always @* begin
      in_en = ~first_port_analog_select;
      in_en[6] = pin6_gpio;
      in_en[7] = !ext_mode;
   end

   // output value and drive per pin, fixed priority
   reg [7:0] next_out;
   reg [7:0] next_drive;
   always @* begin
      next_out   = first_port_output_latch;
      next_drive = ~first_port_direction;
      // bit 4: latch q > comparator 1 > pwm 5 > port latch
      if (periph_en[`PAM_PE_SRQ]) begin
         next_out[4]   = latch_q_output;
         next_drive[4] = 1'b1;
      end else if (periph_en[`PAM_PE_C1]) begin
         next_out[4]   = comparator_one_output;
         next_drive[4] = 1'b1;
      end else if (periph_en[`PAM_PE_COMPARE_PWM_CHANNEL_FIVE]) begin
         next_out[4]   = compare_pwm_channel_five;
         next_drive[4] = 1'b1;
      end
      // bit 5, analog mode does not block these outputs
      if (periph_en[`PAM_PE_LATCH_INVERTED_OUTPUT]) begin
         next_out[5]   = latch_inverted_output;
         next_drive[5] = 1'b1;
      end else if (periph_en[`PAM_PE_C2]) begin
         next_out[5]   = comparator_two_output;
         next_drive[5] = 1'b1;
      end
      // bit 6: oscillator output > clock output > latch
      if (xtal_mode) begin
         next_out[6]   = 1'b0;
         next_drive[6] = 1'b0;
      end else if (instruction_clock_output) begin
         next_out[6]   = quarter_rate_clock;
         next_drive[6] = 1'b1;
      end else if (!pin6_gpio) begin
         next_drive[6] = 1'b0;
      end
      // bit 7: oscillator input > latch
      if (ext_mode) begin
         next_out[7]   = 1'b0;
         next_drive[7] = 1'b0;
      end
   end

   // quarter rate clock: toggles every two core cycles
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         quarter_div        <= 2'h0;
         quarter_rate_clock <= 1'b0;
      end else begin
         quarter_div <= quarter_div + 2'h1;
         if (quarter_div[0])
            quarter_rate_clock <= ~quarter_rate_clock;
      end
   end

   // pin synchroniser, first stage read only by second
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   // register writes
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         first_port_output_latch  <= `PAM_LATCH_RST;
         first_port_direction     <= `PAM_DIR_RST;
         first_port_analog_select <= `PAM_ANSEL_RST;
         slew_rate_control        <= `PAM_SLEW_RST;
         oscillator_select_field  <= `PAM_OSC_RST;
         periph_en                <= `PAM_PERIPH_RST;
      end else if (wr) begin
         case (addr)
            `PAM_OFF_PINS, `PAM_OFF_LATCH:
               first_port_output_latch <= wdata;
            `PAM_OFF_DIR:
               first_port_direction <= wdata;
            `PAM_OFF_ANSEL:
               first_port_analog_select <= wdata & `PAM_ANSEL_MASK;
            `PAM_OFF_SLEW:
               slew_rate_control <= wdata & `PAM_SLEW_MASK;
            `PAM_OFF_OSC:
               oscillator_select_field <= wdata[3:0];
            `PAM_OFF_PERIPH:
               periph_en <= wdata & 8'h1F;
            default: ;
         endcase
      end
   end

   // register reads, data one cycle after the strobe
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `PAM_OFF_PINS:  rdata <= pin_sync & in_en;
            `PAM_OFF_LATCH: rdata <= first_port_output_latch;
            `PAM_OFF_DIR:   rdata <= first_port_direction;
            `PAM_OFF_ANSEL: rdata <= first_port_analog_select;
            `PAM_OFF_SLEW:  rdata <= slew_rate_control;
            `PAM_OFF_OSC:   rdata <= {4'h0, oscillator_select_field};
            `PAM_OFF_PERIPH: rdata <= periph_en;
            default:        rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // registered pin side outputs
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_out        <= 8'h00;
         pin_oe_n       <= 8'hFF;
         pin_slew_limit <= 8'h00;
         analog_connect <= 8'h00;
         osc_out_enable <= 1'b0;
         osc_in_enable  <= 1'b0;
      end else begin
         pin_out        <= next_out;
         pin_oe_n       <= ~next_drive;
         pin_slew_limit <= {3'h0, slew_rate_control[4:0]};
         analog_connect <= first_port_analog_select;
         osc_out_enable <= xtal_mode;
         // clock input is just the oscillator input function
         osc_in_enable  <= ext_mode;
      end
   end

endmodule

// [verif/pam_pins_model.sv]
// board side of port a: loops back driven pins, passes the board level on released ones
`timescale 1ns/1ps
module pam_pins_model (
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe_n,
   input  wire [7:0] board,
   output wire [7:0] pin_in
);
   // released pins follow the board, never the last driven level
   assign pin_in = (pin_out & ~pin_oe_n) | (board & pin_oe_n);
endmodule

// [verif/pam_port_a_mux_bench.sv]
// self-checking bench for the port a pin mux
`timescale 1ns/1ps
`include "pam_defs.vh"
module pam_port_a_mux_bench;
   localparam [55:0] RST = 56'h0000081F2FFF00;
   reg        core_clk = 1'b0;
   reg        resetn = 1'b0;
   reg  [3:0] addr = 4'h0;
   reg  [7:0] wdata = 8'h00;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   reg  [7:0] board = 8'h00;
   reg  [4:0] pv = 5'h00;
   reg  [7:0] v;
   reg  [7:0] e;
   wire [7:0] rdata, pin_in, pin_out, pin_oe_n, acon;
   wire       osc_o, osc_i;
   int        num_errors = 0;
   int        total_checks = 0;
   int        cyc = 0;
   int        i;
   pam_port_a_mux u_pam_port_a_mux (.core_clk, .resetn, .addr, .wdata, .wr,
      .rd, .rdata, .pin_in, .pin_out, .pin_oe_n, .pin_slew_limit(),
      .analog_connect(acon), .osc_out_enable(osc_o), .osc_in_enable(osc_i),
      .latch_q_output(pv[0]), .comparator_one_output(pv[1]),
      .compare_pwm_channel_five(pv[2]), .latch_inverted_output(pv[3]),
      .comparator_two_output(pv[4]));
   pam_pins_model u_pins (.pin_out, .pin_oe_n, .board, .pin_in);
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         close_out;
      end
   end
   task check(input [7:0] seen, input [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wreg(input [3:0] a, input [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task rreg(input [3:0] a, output [7:0] d);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // pins trail config by two flops out and two sync flops back
   task settle;
      repeat (5) @(posedge core_clk);
      #1;
   endtask
   function [1:0] prio(input [4:0] en, input [4:0] p, input [1:0] lat);
      prio[0] = en[0] ? p[0] : en[1] ? p[1] : en[2] ? p[2] : lat[0];
      prio[1] = en[3] ? p[3] : en[4] ? p[4] : lat[1];
   endfunction
   // {osc out, osc in, pin 7 released, pin 6 released}
   function [3:0] osc_exp(input [3:0] c);
      case (c)
         4'h0, 4'h1, 4'h2: osc_exp = 4'hF;
         4'h3: osc_exp = 4'h6;
         4'h8, 4'h9: osc_exp = 4'h0;
         default: osc_exp = 4'h7;
      endcase
   endfunction
   task close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      v = $urandom(32'hABAB);
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      board <= $urandom;
      for (i = 1; i < 8; i++) begin
         rreg(i[3:0], v);
         check(v, RST[8*(i-1)+:8]);
      end
      settle;
      rreg(`PAM_OFF_PINS, v);
      check(v, board & 8'hD0);
      check(acon, 8'h2F);
      wreg(`PAM_OFF_ANSEL, 8'hFF);
      rreg(`PAM_OFF_ANSEL, v);
      check(v, 8'h2F);
      wreg(`PAM_OFF_ANSEL, 8'h00);
      wreg(`PAM_OFF_DIR, 8'h00);
      for (i = 0; i < 8; i++) begin
         e = $urandom;
         wreg(i[0] ? `PAM_OFF_PINS : `PAM_OFF_LATCH, e);
         settle;
         rreg(`PAM_OFF_PINS, v);
         check(v, e);
      end
      // analog mode on pin 5 must not stop the outputs
      wreg(`PAM_OFF_ANSEL, 8'h20);
      // pins released by direction so only enabled peripherals drive
      wreg(`PAM_OFF_DIR, 8'hFF);
      for (i = 0; i < 24; i++) begin
         e = (i == 0) ? 8'hFF : $urandom;
         v = $urandom;
         wreg(`PAM_OFF_PERIPH, {3'h0, e[4:0]});
         wreg(`PAM_OFF_LATCH, v);
         @(posedge core_clk);
         pv <= $urandom;
         settle;
         check({6'h00, pin_out[5:4]}, {6'h00, prio(e[4:0], pv, v[5:4])});
         check({6'h00, pin_oe_n[5:4]},
               {6'h00, ~(e[3] | e[4]), ~(e[0] | e[1] | e[2])});
      end
      wreg(`PAM_OFF_PERIPH, 8'h00);
      wreg(`PAM_OFF_DIR, 8'h00);
      wreg(`PAM_OFF_LATCH, 8'hC0);
      for (i = 0; i < 16; i++) begin
         wreg(`PAM_OFF_OSC, i[3:0]);
         settle;
         e = {4'h0, osc_o, osc_i, pin_oe_n[7], pin_oe_n[6]};
         check(e, {4'h0, osc_exp(i[3:0])});
         rreg(`PAM_OFF_PINS, v);
         check({6'h00, v[7:6]}, {6'h00, i > 7 && i < 10, i == 8});
         if (i == 3 || i == 9) repeat (6) begin
            v[0] = pin_out[6];
            repeat (2) @(posedge core_clk);
            #1;
            check({7'h00, pin_out[6]}, {7'h00, ~v[0]});
         end
      end
      close_out;
   end
endmodule

// [verif/pam_port_a_mux_props.sv]
// port-level assertions for the port a pin mux
`timescale 1ns/1ps
`include "pam_defs.vh"
module pam_port_a_mux_props (
   input wire       core_clk,
   input wire       resetn,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   input wire [7:0] pin_out,
   input wire [7:0] pin_oe_n,
   input wire [7:0] pin_slew_limit,
   input wire [7:0] analog_connect,
   input wire       osc_out_enable,
   input wire       osc_in_enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // a quiet cycle after the write keeps the two-cycle pipe undisturbed
   sequence dir_wr;
      wr && addr == `PAM_OFF_DIR ##1 !wr;
   endsequence
   sequence lat_wr;
      wr && addr == `PAM_OFF_LATCH ##1 !wr;
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   crystal_owns_in_a: assert property (osc_out_enable |-> osc_in_enable)
      else $error("osc output without osc input");
   osc_pin_free_a: assert property (osc_in_enable |-> pin_oe_n[7])
      else $error("pin 7 driven in external osc mode");
   ansel_gaps_a: assert property (
      analog_connect[7:6] == 2'b00 && !analog_connect[4])
      else $error("analog on unimplemented pin");
   slew_gaps_a: assert property (pin_slew_limit[7:5] == 3'h0)
      else $error("slew bits above 4 set");
   dir_follow_a: assert property (
      dir_wr |=> pin_oe_n[3:0] == $past(wdata[3:0], 2))
      else $error("direction not applied");
   latch_follow_a: assert property (
      lat_wr |=> ((pin_out[3:0] ^ $past(wdata[3:0], 2))
                  & ~pin_oe_n[3:0]) == 4'h0)
      else $error("latch not on driven pin");
   read_mask_a: assert property (
      rd && addr == `PAM_OFF_PINS |=> (rdata & analog_connect) == 8'h00
      && !(osc_in_enable && rdata[7]))
      else $error("disabled input seen in read");
endmodule
bind pam_port_a_mux pam_port_a_mux_props u_props (.core_clk, .resetn, .addr,
   .wdata, .wr, .rd, .rdata, .pin_out, .pin_oe_n, .pin_slew_limit,
   .analog_connect, .osc_out_enable, .osc_in_enable);
